// ===== rtl/bbpp_pkg.sv
// bbpp_pkg: constants and types for the bit-bang parallel port
// assumes: one 200 MHz system clock, host command port of plain strobes
package bbpp_pkg;
	// ------------------------------------------------------------
	// register map (word index = byte address / 4)
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_MODE_A = 4'h0;
	localparam logic [3:0] ADDR_DIR_A = 4'h1;
	localparam logic [3:0] ADDR_DATA_A = 4'h2;
	localparam logic [3:0] ADDR_STAT_A = 4'h3;
	localparam logic [3:0] ADDR_MODE_B = 4'h4;
	localparam logic [3:0] ADDR_DIR_B = 4'h5;
	localparam logic [3:0] ADDR_DATA_B = 4'h6;
	localparam logic [3:0] ADDR_STAT_B = 4'h7;
	localparam logic [3:0] ADDR_BAUD = 4'h8;
	localparam logic [3:0] ADDR_CFG = 4'h9;
	// ------------------------------------------------------------
	// pin-mode command codes
	// ------------------------------------------------------------
	localparam logic [7:0] PMODE_RESET = 8'h00;
	localparam logic [7:0] PMODE_ASYNC = 8'h01;
	localparam logic [7:0] PMODE_SSE = 8'h02;
	localparam logic [7:0] PMODE_SYNC = 8'h04;
	// ------------------------------------------------------------
	// primary channel modes (cfg register field codes)
	// ------------------------------------------------------------
	localparam logic [1:0] PRIM_FIFO = 2'h0;
	localparam logic [1:0] PRIM_CPU = 2'h1;
	localparam logic [1:0] PRIM_FISO = 2'h2;
	localparam logic [1:0] PRIM_UART = 2'h3;
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int CFG_PRIM_A_LSB = 0;
	localparam int CFG_PRIM_B_LSB = 2;
	localparam int CFG_PULLDN_BIT = 4;
	localparam int CFG_SUSP_BIT = 5;
	localparam logic [15:0] BAUD_RESET = 16'h00C8;
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// ------------------------------------------------------------
	// timing: fastest advised baud tick period and the clock rate
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int MIN_TICK_NS = 1000;
	localparam int MIN_TICK_CYC = (MIN_TICK_NS * CLK_MHZ + 999) / 1000;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [5:0] {
		BBPP_IDLE = 6'b00_0001,
		BBPP_SAMP = 6'b00_0010,
		BBPP_RDHI = 6'b00_0100,
		BBPP_SETUP = 6'b00_1000,
		BBPP_WRLO = 6'b01_0000,
		BBPP_WRHI = 6'b10_0000
	} bbpp_state_t;
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic wr_n;
		logic rd_n;
	} bbpp_pins_t;
endpackage

// ===== rtl/bbpp_port.sv
// bbpp_port: two-channel bit-bang parallel port with register access
// assumes: synchronous pin inputs, host obeys the advised baud limit
// Summary of operation
// - active bit-bang mode turns a channel's eight lines into one data bus
// - channels A and B operate bit-bang independently or together
// - per-pin direction; written data drives only output pins
// - async mode clocks written bytes out at the baud generator pace
// - async pins change only on new byte plus tick, else hold
// - async mode drives only the write strobe out on pins
// - async mode entered by code 0x01, left by 0x00
// - sync mode outputs a byte only with receive room
// - sync mode samples pins before driving each new byte
// - sync order: sample, read high, read low and drive, setup, write
// - sync mode entered by 0x04, left by 0x00, strobes off chip
// - fifo, cpu or fast serial primary uses the main strobe pins
// - uart primary moves the strobes to the alternate pins
// - channel B refuses bit-bang while fast serial is primary
// - input pins pulled low in suspend when config bit set
// - sync serial engine exists on channel A only, code 0x02
// - suspend indicator output is one while suspended
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module bbpp_port #(
	parameter int CH = 2
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic [7:0] pin_a_i,
	input wire logic [7:0] pin_b_i,
	output logic [7:0] pin_a_o,
	output logic [7:0] pin_b_o,
	output logic [7:0] pin_a_oe_o,
	output logic [7:0] pin_b_oe_o,
	output logic [7:0] pin_a_pulldn_o,
	output logic [7:0] pin_b_pulldn_o,
	output logic [1:0] strb_main_wr_n_o,
	output logic [1:0] strb_main_rd_n_o,
	output logic [1:0] strb_alt_wr_n_o,
	output logic [1:0] strb_alt_rd_n_o,
	output logic sse_active_o,
	output logic suspend_indicator_o
);
	// ------------------------------------------------------------
	// shared configuration
	// ------------------------------------------------------------
	logic [15:0] baud_q;
	logic [5:0] cfg_q;
	logic [15:0] bcnt_q;
	logic tick;
	logic [7:0] pin_in [CH];
	logic [7:0] rd_mode [CH];
	logic [7:0] rd_dir [CH];
	logic [7:0] rd_stat [CH];
	logic [7:0] rd_samp [CH];
	bbpp_pkg::bbpp_pins_t pins [CH];
	logic [1:0] prim [CH];

	assign pin_in[0] = pin_a_i;
	assign pin_in[1] = pin_b_i;
	assign prim[0] = cfg_q[bbpp_pkg::CFG_PRIM_A_LSB +: 2];
	assign prim[1] = cfg_q[bbpp_pkg::CFG_PRIM_B_LSB +: 2];
	assign tick = (bcnt_q == 16'h0000);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			baud_q <= bbpp_pkg::BAUD_RESET;
			cfg_q <= 6'h00;
		end else if (clk_en_i && wr_i) begin
			if (addr_i == bbpp_pkg::ADDR_BAUD)
				baud_q <= wdata_i;
			if (addr_i == bbpp_pkg::ADDR_CFG)
				cfg_q <= wdata_i[5:0];
		end
	end

	// baud generator: one tick every baud_q + 1 cycles
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			bcnt_q <= 16'h0000;
		else if (clk_en_i)
			bcnt_q <= tick ? baud_q : bcnt_q - 16'h0001;
	end

	// ------------------------------------------------------------
	// per-channel engine
	// ------------------------------------------------------------
	for (genvar c = 0; c < CH; c++) begin : g_ch
		localparam logic [3:0] AM = c ? bbpp_pkg::ADDR_MODE_B
			: bbpp_pkg::ADDR_MODE_A;
		localparam logic [3:0] AD = c ? bbpp_pkg::ADDR_DIR_B
			: bbpp_pkg::ADDR_DIR_A;
		localparam logic [3:0] AT = c ? bbpp_pkg::ADDR_DATA_B
			: bbpp_pkg::ADDR_DATA_A;
		localparam logic [3:0] AS = c ? bbpp_pkg::ADDR_STAT_B
			: bbpp_pkg::ADDR_STAT_A;
		logic [7:0] mode_q;
		logic [7:0] dir_q;
		logic [7:0] out_q;
		logic [7:0] pend_q;
		logic pend_v_q;
		logic [7:0] samp_q;
		logic samp_v_q;
		logic wr_n_q;
		logic rd_n_q;
		logic ovf_q;
		bbpp_pkg::bbpp_state_t st_q;
		logic refuse;
		logic bb_on;
		logic is_async;
		logic is_sync;
		logic wr_hit;
		logic rd_take;

		// channel B has no bit-bang under fast serial primary
		assign refuse = (c == 1) && (prim[c] == bbpp_pkg::PRIM_FISO);
		assign is_async = (mode_q == bbpp_pkg::PMODE_ASYNC);
		assign is_sync = (mode_q == bbpp_pkg::PMODE_SYNC);
		assign bb_on = is_async || is_sync;
		assign wr_hit = clk_en_i && wr_i && (addr_i == AT);
		assign rd_take = clk_en_i && rd_i && (addr_i == AT);

		// mode command; bad codes and refused modes fall back to primary
		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				mode_q <= bbpp_pkg::PMODE_RESET;
			end else if (clk_en_i && wr_i && addr_i == AM) begin
				case (wdata_i[7:0])
					bbpp_pkg::PMODE_ASYNC:
						mode_q <= refuse ? bbpp_pkg::PMODE_RESET
							: bbpp_pkg::PMODE_ASYNC;
					bbpp_pkg::PMODE_SYNC:
						mode_q <= refuse ? bbpp_pkg::PMODE_RESET
							: bbpp_pkg::PMODE_SYNC;
					bbpp_pkg::PMODE_SSE:
						mode_q <= (c == 0) ? bbpp_pkg::PMODE_SSE
							: bbpp_pkg::PMODE_RESET;
					default:
						mode_q <= bbpp_pkg::PMODE_RESET;
				endcase
			end else if (refuse && bb_on) begin
				mode_q <= bbpp_pkg::PMODE_RESET;
			end
		end

		always_ff @(posedge sys_clk_i) begin
			if (rst_i)
				dir_q <= bbpp_pkg::DIR_RESET;
			else if (clk_en_i && wr_i && addr_i == AD)
				dir_q <= wdata_i[7:0];
		end

		// pending byte from the host, one deep
		always_ff @(posedge sys_clk_i) begin
			if (rst_i || (clk_en_i && !bb_on)) begin
				pend_v_q <= 1'b0;
				pend_q <= bbpp_pkg::DATA_RESET;
			end else if (clk_en_i) begin
				if (wr_hit) begin
					pend_q <= wdata_i[7:0];
					pend_v_q <= 1'b1;
				end else if ((is_async && tick && st_q == bbpp_pkg::BBPP_IDLE)
					|| st_q == bbpp_pkg::BBPP_SAMP) begin
					pend_v_q <= 1'b0;
				end
			end
		end

		// strobe and transfer sequencer
		always_ff @(posedge sys_clk_i) begin
			if (rst_i || (clk_en_i && !bb_on)) begin
				st_q <= bbpp_pkg::BBPP_IDLE;
				wr_n_q <= 1'b1;
				rd_n_q <= 1'b1;
				out_q <= bbpp_pkg::DATA_RESET;
			end else if (clk_en_i) begin
				case (st_q)
					bbpp_pkg::BBPP_IDLE: begin
						rd_n_q <= 1'b1;
						wr_n_q <= 1'b1;
						if (pend_v_q && !wr_hit && tick) begin
							if (is_async) begin
								out_q <= pend_q;
								wr_n_q <= 1'b0;
								st_q <= bbpp_pkg::BBPP_WRHI;
							end else if (!samp_v_q || rd_take) begin
								rd_n_q <= 1'b0;
								st_q <= bbpp_pkg::BBPP_SAMP;
							end
						end
					end
					bbpp_pkg::BBPP_SAMP: begin
						rd_n_q <= 1'b1;
						st_q <= bbpp_pkg::BBPP_RDHI;
					end
					bbpp_pkg::BBPP_RDHI: begin
						rd_n_q <= 1'b0;
						out_q <= pend_q;
						st_q <= bbpp_pkg::BBPP_SETUP;
					end
					bbpp_pkg::BBPP_SETUP: begin
						st_q <= bbpp_pkg::BBPP_WRLO;
					end
					bbpp_pkg::BBPP_WRLO: begin
						wr_n_q <= 1'b0;
						st_q <= bbpp_pkg::BBPP_WRHI;
					end
					bbpp_pkg::BBPP_WRHI: begin
						wr_n_q <= 1'b1;
						rd_n_q <= 1'b1;
						st_q <= bbpp_pkg::BBPP_IDLE;
					end
					default: begin
						st_q <= bbpp_pkg::BBPP_IDLE;
					end
				endcase
			end
		end

		// sync return sample; async mode reads live pins
		always_ff @(posedge sys_clk_i) begin
			if (rst_i || (clk_en_i && !bb_on)) begin
				samp_q <= 8'h00;
				samp_v_q <= 1'b0;
				ovf_q <= 1'b0;
			end else if (clk_en_i) begin
				if (st_q == bbpp_pkg::BBPP_SAMP && is_sync) begin
					samp_q <= pin_in[c];
					samp_v_q <= 1'b1;
				end else if (rd_take) begin
					samp_v_q <= 1'b0;
				end
				if (wr_hit && pend_v_q)
					ovf_q <= 1'b1;
				else if (clk_en_i && rd_i && addr_i == AS)
					ovf_q <= 1'b0;
			end
		end

		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				pins[c] <= '{out: 8'h00, oe: 8'h00, wr_n: 1'b1, rd_n: 1'b1};
			end else if (clk_en_i) begin
				pins[c].out <= out_q & dir_q;
				pins[c].oe <= bb_on ? dir_q : 8'h00;
				pins[c].wr_n <= wr_n_q;
				pins[c].rd_n <= rd_n_q;
			end
		end

		assign rd_mode[c] = mode_q;
		assign rd_dir[c] = dir_q;
		assign rd_samp[c] = is_sync ? samp_q : pin_in[c];
		assign rd_stat[c] = {st_q != bbpp_pkg::BBPP_IDLE, ovf_q, refuse,
			samp_v_q, pend_v_q, bb_on, is_sync, is_async};
	end

	// ------------------------------------------------------------
	// pin outputs, strobe routing and suspend
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			pin_a_o <= 8'h00;
			pin_b_o <= 8'h00;
			pin_a_oe_o <= 8'h00;
			pin_b_oe_o <= 8'h00;
			pin_a_pulldn_o <= 8'h00;
			pin_b_pulldn_o <= 8'h00;
			suspend_indicator_o <= 1'b0;
			sse_active_o <= 1'b0;
		end else if (clk_en_i) begin
			pin_a_o <= pins[0].out;
			pin_b_o <= pins[1].out;
			pin_a_oe_o <= pins[0].oe;
			pin_b_oe_o <= pins[1].oe;
			suspend_indicator_o <= cfg_q[bbpp_pkg::CFG_SUSP_BIT];
			pin_a_pulldn_o <= (cfg_q[bbpp_pkg::CFG_SUSP_BIT]
				&& cfg_q[bbpp_pkg::CFG_PULLDN_BIT])
				? ~pins[0].oe : 8'h00;
			pin_b_pulldn_o <= (cfg_q[bbpp_pkg::CFG_SUSP_BIT]
				&& cfg_q[bbpp_pkg::CFG_PULLDN_BIT])
				? ~pins[1].oe : 8'h00;
			sse_active_o <= (rd_mode[0] == bbpp_pkg::PMODE_SSE);
		end
	end

	for (genvar s = 0; s < CH; s++) begin : g_strb
		always_ff @(posedge sys_clk_i) begin
			if (rst_i) begin
				strb_main_wr_n_o[s] <= 1'b1;
				strb_main_rd_n_o[s] <= 1'b1;
				strb_alt_wr_n_o[s] <= 1'b1;
				strb_alt_rd_n_o[s] <= 1'b1;
			end else if (clk_en_i) begin
				if (prim[s] == bbpp_pkg::PRIM_UART) begin
					strb_alt_wr_n_o[s] <= pins[s].wr_n;
					strb_alt_rd_n_o[s] <= pins[s].rd_n;
					strb_main_wr_n_o[s] <= 1'b1;
					strb_main_rd_n_o[s] <= 1'b1;
				end else begin
					strb_main_wr_n_o[s] <= pins[s].wr_n;
					strb_main_rd_n_o[s] <= pins[s].rd_n;
					strb_alt_wr_n_o[s] <= 1'b1;
					strb_alt_rd_n_o[s] <= 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_o <= 16'h0000;
		end else if (clk_en_i) begin
			rdata_o <= 16'h0000;
			if (rd_i) begin
				case (addr_i)
					bbpp_pkg::ADDR_MODE_A: rdata_o <= {8'h00, rd_mode[0]};
					bbpp_pkg::ADDR_DIR_A: rdata_o <= {8'h00, rd_dir[0]};
					bbpp_pkg::ADDR_DATA_A: rdata_o <= {8'h00, rd_samp[0]};
					bbpp_pkg::ADDR_STAT_A: rdata_o <= {8'h00, rd_stat[0]};
					bbpp_pkg::ADDR_MODE_B: rdata_o <= {8'h00, rd_mode[1]};
					bbpp_pkg::ADDR_DIR_B: rdata_o <= {8'h00, rd_dir[1]};
					bbpp_pkg::ADDR_DATA_B: rdata_o <= {8'h00, rd_samp[1]};
					bbpp_pkg::ADDR_STAT_B: rdata_o <= {8'h00, rd_stat[1]};
					bbpp_pkg::ADDR_BAUD: rdata_o <= baud_q;
					bbpp_pkg::ADDR_CFG: rdata_o <= {10'h000, cfg_q};
					default: rdata_o <= 16'h0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/bbpp_props.sv
// bbpp_props: assertions on the strobes and pins of bbpp_port
// assumes: clk_en_i held high, bound to every bbpp_port instance
`timescale 1ns/1ps
`default_nettype none
module bbpp_props (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic [7:0] pin_a_o,
	input wire logic [7:0] pin_a_oe_o,
	input wire logic [7:0] pin_b_oe_o,
	input wire logic [1:0] strb_main_wr_n_o,
	input wire logic [1:0] strb_main_rd_n_o,
	input wire logic [1:0] strb_alt_wr_n_o,
	input wire logic [1:0] strb_alt_rd_n_o,
	input wire logic sse_active_o,
	input wire logic suspend_indicator_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	logic [1:0] prim_b_q;
	logic wr_a_n;
	logic rd_a_n;
	logic mode_a_wr;
	assign wr_a_n = strb_main_wr_n_o[0] & strb_alt_wr_n_o[0];
	assign rd_a_n = strb_main_rd_n_o[0] & strb_alt_rd_n_o[0];
	assign mode_a_wr = wr_i && addr_i == bbpp_pkg::ADDR_MODE_A;
	// shadow of the channel B primary mode field
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			prim_b_q <= 2'h0;
		end else if (wr_i && addr_i == bbpp_pkg::ADDR_CFG) begin
			prim_b_q <= wdata_i[3:2];
		end
	end
	chk_reset_idle:
	assert property ($fell(rst_i) |-> pin_a_oe_o == 8'h00 && &strb_main_wr_n_o
		&& &strb_main_rd_n_o && !suspend_indicator_o)
		else $error("outputs not idle after reset");
	chk_leave_mode:
	assert property (mode_a_wr && wdata_i[7:0] == bbpp_pkg::PMODE_RESET
		|-> ##4 pin_a_oe_o == 8'h00 && wr_a_n && rd_a_n)
		else $error("channel a still active after mode reset");
	chk_strb_pair:
	assert property (!strb_main_wr_n_o[0] || !strb_main_rd_n_o[0]
		|-> strb_alt_wr_n_o[0] && strb_alt_rd_n_o[0])
		else $error("both strobe pairs active");
	chk_wr_pulse:
	assert property ($fell(wr_a_n) |=> $rose(wr_a_n))
		else $error("write strobe not one cycle");
	chk_sync_order:
	assert property ($fell(wr_a_n) && !rd_a_n |-> !$past(rd_a_n) &&
		!$past(rd_a_n, 2) && $past(rd_a_n, 3) && !$past(rd_a_n, 4)
		##1 (rd_a_n && wr_a_n))
		else $error("sync strobe order wrong");
	chk_pin_hold:
	assert property ($changed(pin_a_o) && $stable(pin_a_oe_o) &&
		pin_a_oe_o != 8'h00 |-> !wr_a_n || !rd_a_n)
		else $error("pins changed without a strobe");
	chk_b_refused:
	assert property (wr_i && addr_i == bbpp_pkg::ADDR_MODE_B &&
		prim_b_q == bbpp_pkg::PRIM_FISO |-> ##4 pin_b_oe_o == 8'h00 &&
		strb_main_wr_n_o[1] && strb_main_rd_n_o[1])
		else $error("channel b bit-bang not refused");
	chk_sse_entry:
	assert property (mode_a_wr && wdata_i[7:0] == bbpp_pkg::PMODE_SSE
		|-> ##3 sse_active_o)
		else $error("engine mode not entered");
	chk_suspend:
	assert property (wr_i && addr_i == bbpp_pkg::ADDR_CFG
		|-> ##4 suspend_indicator_o == $past(wdata_i[5], 4))
		else $error("suspend indicator wrong");
endmodule
bind bbpp_port bbpp_props chk_u (.*);
`default_nettype wire

// ===== sim/bbpp_far.sv
// bbpp_far: external logic on one channel, clocked by clk_i, capturing on the write strobe
// assumes: undriven lines are driven by this logic with a fixed pattern
`timescale 1ns/1ps
`default_nettype none
module bbpp_far #(
	parameter logic [7:0] EXT = 8'h96
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] out_i,
	input wire logic [7:0] oe_i,
	input wire logic wr_n_i,
	output logic [7:0] pin_o,
	output logic [7:0] last_o,
	output logic [7:0] cnt_o
);
	logic wr_n_q;
	// port drives its output bits, the far logic the rest
	assign pin_o = (out_i & oe_i) | (EXT & ~oe_i);
	// bus captured on each rising write strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_n_q <= 1'b1;
			last_o <= 8'h00;
			cnt_o <= 8'h00;
		end else begin
			wr_n_q <= wr_n_i;
			if (wr_n_i && !wr_n_q) begin
				last_o <= pin_o;
				cnt_o <= cnt_o + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ===== sim/bbpp_port_tb.sv
// bbpp_port_tb: register-level tests of the bit-bang port
// assumes: far logic models on both channels, clock enable held high
`timescale 1ns/1ps
`default_nettype none
module bbpp_port_tb;
	logic sys_clk, rst, wr, rd, sse, susp;
	logic [3:0] addr;
	logic [15:0] wdata, rdata;
	logic [7:0] pa, pb, poa, pob, oea, oeb, pda, pdb, la, lb, ca, cb, c;
	logic [1:0] mw, mr, aw, ar;
	int failures, checks_done;
	bbpp_port dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .clk_en_i(1'b1),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .pin_a_i(pa), .pin_b_i(pb), .pin_a_o(poa),
		.pin_b_o(pob), .pin_a_oe_o(oea), .pin_b_oe_o(oeb),
		.pin_a_pulldn_o(pda), .pin_b_pulldn_o(pdb), .strb_main_wr_n_o(mw),
		.strb_main_rd_n_o(mr), .strb_alt_wr_n_o(aw), .strb_alt_rd_n_o(ar),
		.sse_active_o(sse), .suspend_indicator_o(susp));
	bbpp_far far_a (.clk_i(sys_clk), .rst_i(rst), .out_i(poa), .oe_i(oea),
		.wr_n_i(mw[0] & aw[0]), .pin_o(pa), .last_o(la), .cnt_o(ca));
	bbpp_far far_b (.clk_i(sys_clk), .rst_i(rst), .out_i(pob), .oe_i(oeb),
		.wr_n_i(mw[1] & aw[1]), .pin_o(pb), .last_o(lb), .cnt_o(cb));
	task automatic summarize();
		if (failures == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		cmp(rdata, e);
	endtask
	task automatic wait_pins(input logic [15:0] e);
		int n;
		n = 0;
		while ({pob, poa} !== e && n < 2000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		cmp({pob, poa}, e);
	endtask
	task automatic wait_wr(input logic [7:0] s);
		int n;
		n = 0;
		while (ca === s && n < 2000) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		cmp({8'h00, ca}, {8'h00, s + 8'h01});
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		#200000;
		failures++;
		summarize();
	end
	initial begin
		{rst, wr, rd, addr, wdata} = {1'b1, 22'h0};
		failures = 0;
		checks_done = 0;
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		cmp({oea, mw, mr, aw, ar}, 16'h00ff);
		rd_reg(bbpp_pkg::ADDR_BAUD, 16'h00c8);
		rd_reg(4'hf, 16'h0000);
		wr_reg(bbpp_pkg::ADDR_MODE_A, 16'h0001);
		wr_reg(bbpp_pkg::ADDR_DIR_A, 16'h000f);
		wr_reg(bbpp_pkg::ADDR_DATA_A, 16'h00a5);
		wait_pins(16'h0005);
		cmp({8'h00, oea}, 16'h000f);
		repeat (2) @(posedge sys_clk);
		#1;
		cmp({8'h00, la}, 16'h0095);
		rd_reg(bbpp_pkg::ADDR_DATA_A, 16'h0095);
		wr_reg(bbpp_pkg::ADDR_MODE_B, 16'h0001);
		wr_reg(bbpp_pkg::ADDR_DIR_B, 16'h00ff);
		wr_reg(bbpp_pkg::ADDR_DATA_B, 16'h003c);
		wait_pins(16'h3c05);
		wr_reg(bbpp_pkg::ADDR_MODE_A, 16'h0000);
		wr_reg(bbpp_pkg::ADDR_MODE_A, 16'h0004);
		wr_reg(bbpp_pkg::ADDR_DIR_A, 16'h00ff);
		c = ca;
		wr_reg(bbpp_pkg::ADDR_DATA_A, 16'h0055);
		wait_wr(c);
		c = ca;
		wr_reg(bbpp_pkg::ADDR_DATA_A, 16'h00aa);
		repeat (600) @(posedge sys_clk);
		#1;
		cmp({8'h00, poa}, 16'h0055);
		rd_reg(bbpp_pkg::ADDR_STAT_A, 16'h001e);
		rd_reg(bbpp_pkg::ADDR_DATA_A, 16'h0000);
		wait_wr(c);
		cmp({8'h00, la}, 16'h00aa);
		c = ca;
		rd_reg(bbpp_pkg::ADDR_DATA_A, 16'h0055);
		wr_reg(bbpp_pkg::ADDR_DATA_A, 16'h00aa);
		wait_wr(c);
		rd_reg(bbpp_pkg::ADDR_DATA_A, 16'h00aa);
		wr_reg(bbpp_pkg::ADDR_CFG, 16'h0003);
		wr_reg(bbpp_pkg::ADDR_MODE_A, 16'h0001);
		c = ca;
		wr_reg(bbpp_pkg::ADDR_DATA_A, 16'h0033);
		wait_wr(c);
		cmp({8'h00, la}, 16'h0033);
		wr_reg(bbpp_pkg::ADDR_CFG, 16'h0008);
		wr_reg(bbpp_pkg::ADDR_MODE_B, 16'h0001);
		rd_reg(bbpp_pkg::ADDR_MODE_B, 16'h0000);
		wr_reg(bbpp_pkg::ADDR_MODE_A, 16'h0002);
		wr_reg(bbpp_pkg::ADDR_MODE_B, 16'h0002);
		rd_reg(bbpp_pkg::ADDR_MODE_B, 16'h0000);
		cmp({15'h0000, sse}, 16'h0001);
		wr_reg(bbpp_pkg::ADDR_MODE_A, 16'h0001);
		wr_reg(bbpp_pkg::ADDR_DIR_A, 16'h000f);
		wr_reg(bbpp_pkg::ADDR_CFG, 16'h0030);
		repeat (5) @(posedge sys_clk);
		#1;
		cmp({7'h00, susp, pda}, 16'h01f0);
		cmp({pdb, 8'h00}, 16'hff00);
		wr_reg(bbpp_pkg::ADDR_MODE_A, 16'h0000);
		repeat (5) @(posedge sys_clk);
		#1;
		cmp({oea, mw, mr, aw, ar}, 16'h00ff);
		summarize();
	end
endmodule
`default_nettype wire
